// >>> dv/bam_core_tb.sv
// Purpose: self-checking bench for the byte alu datapath over classic wishbone
// Assumes: ack comes one cycle after a request, results settle once busy drops
// Notes:   every command launched through exec also has its busy and closed-window cycles counted
`timescale 1ns/100ps
module bam_core_tb
	import bam_pkg::*;
;
	logic        i_core_clk;
	logic        i_rst;
	logic        i_wb_cyc;
	logic        i_wb_stb;
	logic        i_wb_we;
	logic [7:0]  i_wb_adr;
	logic [3:0]  i_wb_sel;
	logic [31:0] i_wb_dat;
	logic [31:0] o_wb_dat;
	logic        o_wb_ack;
	logic [7:0]  i_port_one_pins;
	logic [7:0]  i_port_three_pins;
	logic [7:0]  o_port_one;
	logic [7:0]  o_port_three;
	logic [7:0]  o_port_seven;
	logic        o_busy;
	logic        o_int_window;
	int          err_total;
	int          n_compared;
	logic [71:0] md_tab [4];
	logic [31:0] lg_tab [12];

	bam_core bam_core_inst (
		.i_core_clk(i_core_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
		.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
		.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_port_one_pins(i_port_one_pins),
		.i_port_three_pins(i_port_three_pins), .o_port_one(o_port_one),
		.o_port_three(o_port_three), .o_port_seven(o_port_seven), .o_busy(o_busy),
		.o_int_window(o_int_window)
	);

	// 40 mhz core clock
	always #12.5 i_core_clk = ~i_core_clk;

	// verdict and end of run
	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// compare a register or port value
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("BAD value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// compare a cycle count measured by the bench
	task automatic chk_cnt(input int got, input int exp);
		n_compared++;
		if (got != exp) begin
			err_total++;
			$display("BAD count at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one classic cycle, held until ack is sampled high
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge i_core_clk);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we  <= we;
		i_wb_adr <= adr;
		i_wb_sel <= 4'h3;
		i_wb_dat <= wd;
		// only the watchdog ends a wait for ack
		do begin
			@(posedge i_core_clk);
		end while (o_wb_ack !== 1'b1);
		rd = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		i_wb_we  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [7:0] v);
		logic [31:0] d;
		wb_cycle(1'b1, adr, {24'h0, v}, d);
	endtask

	task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] d;
		wb_cycle(1'b0, adr, 32'h0, d);
		chk_val(d, exp);
	endtask

	// write one byte of the data array
	task automatic setm(input logic [8:0] a, input logic [7:0] v);
		logic [31:0] d;
		wb_cycle(1'b1, BAM_REG_MEM_ADDR, {23'h0, a}, d);
		wr(BAM_REG_MEM_DATA, v);
	endtask

	// launch a command and count busy and closed-window cycles
	task automatic exec(input logic [7:0] op, input logic [7:0] imm, input int en, input int ew);
		logic [31:0] d;
		int          n;
		int          w;
		n = 0;
		w = 0;
		wb_cycle(1'b1, BAM_REG_CMD, {16'h0, imm, op}, d);
		while (o_busy === 1'b1 && n < 20) begin
			n++;
			if (o_int_window !== 1'b1) w++;
			@(posedge i_core_clk);
		end
		chk_cnt(n, en);
		chk_cnt(w, ew);
	endtask

	// watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge i_core_clk);
		err_total++;
		end_of_test();
	end

	// main sequence
	initial begin
		logic [7:0] f [9];
		i_core_clk = 1'b0;
		i_rst = 1'b1;
		i_wb_cyc = 1'b0;
		i_wb_stb = 1'b0;
		i_wb_we = 1'b0;
		i_wb_adr = 8'h00;
		i_wb_sel = 4'h0;
		i_wb_dat = 32'h0;
		i_port_one_pins = 8'haa;
		i_port_three_pins = 8'h55;
		err_total = 0;
		n_compared = 0;
		// psw, acc, c, b, op, then expected acc, c, b, psw
		md_tab = '{72'hc0_11_23_52_30_7d_36_05_44, 72'hc4_07_05_10_30_70_50_00_40,
			72'hc4_79_05_07_40_11_49_06_40, 72'hc0_07_10_00_40_ff_10_00_44};
		// acc in, opcode, second byte, expected acc
		lg_tab = '{32'hff_e1_fa_fa, 32'hff_e2_23_55, 32'hff_e3_02_fe, 32'hff_e4_00_f0,
			32'h00_d1_03_03, 32'h00_d2_23_55, 32'haa_d3_02_fe, 32'h00_d4_00_f0,
			32'h0f_f1_f0_ff, 32'h00_f2_23_55, 32'hff_f3_02_01, 32'h0f_f4_00_ff};
		repeat (2) @(posedge i_core_clk);
		i_rst <= 1'b0;
		// reset state, unmapped place and pin readback
		rdchk(BAM_REG_ACC, 32'h0);
		rdchk(BAM_REG_PSW, 32'h0);
		rdchk(BAM_REG_STATUS, 32'h2);
		chk_val({8'h0, o_port_one, o_port_three, o_port_seven}, 32'h0);
		rdchk(8'h30, 32'h0);
		rdchk(BAM_REG_PINS, 32'h55aa);
		// decrement through pointers: wrap, flags, port latches
		setm(9'h000, 8'h68);
		setm(9'h068, 8'h00);
		setm(9'h002, 8'h44);
		setm(9'h003, 8'h4c);
		wr(BAM_REG_PSW, 8'hc4);
		wr(BAM_REG_PORT1, 8'h10);
		wr(BAM_REG_PORT7, 8'h33);
		exec(8'h74, 8'h00, 1, 0);
		wr(BAM_REG_MEM_ADDR, 8'h68);
		rdchk(BAM_REG_MEM_DATA, 32'hff);
		rdchk(BAM_REG_PSW, 32'hc4);
		exec(8'h76, 8'h00, 1, 0);
		chk_val({24'h0, o_port_one}, 32'h0f);
		exec(8'h77, 8'h00, 1, 0);
		chk_val({24'h0, o_port_three}, 32'hff);
		setm(9'h003, 8'h5c);
		exec(8'h77, 8'h00, 1, 0);
		chk_val({24'h0, o_port_seven}, 32'h33);
		// multiply and divide, with and without overflow
		for (int i = 0; i < 4; i++) begin
			{f[0], f[1], f[2], f[3], f[4], f[5], f[6], f[7], f[8]} = md_tab[i];
			wr(BAM_REG_PSW, f[0]);
			wr(BAM_REG_ACC, f[1]);
			wr(BAM_REG_CREG, f[2]);
			wr(BAM_REG_BREG, f[3]);
			exec(f[4], 8'h00, 7, 6);
			rdchk(BAM_REG_ACC, {24'h0, f[5]});
			rdchk(BAM_REG_CREG, {24'h0, f[6]});
			rdchk(BAM_REG_BREG, {24'h0, f[7]});
			rdchk(BAM_REG_PSW, {24'h0, f[8]});
		end
		// refused write and closed window while a multiply runs
		wr(BAM_REG_ACC, 8'h02);
		wr(BAM_REG_CREG, 8'h03);
		wr(BAM_REG_BREG, 8'h04);
		wr(BAM_REG_CMD, BAM_OP_MUL);
		rdchk(BAM_REG_STATUS, 32'h1);
		wr(BAM_REG_ACC, 8'h99);
		repeat (2) @(posedge i_core_clk);
		rdchk(BAM_REG_ACC, 32'h08);
		rdchk(BAM_REG_CREG, 32'h0c);
		// and, or, xor in immediate, direct and indirect forms
		setm(9'h068, 8'hf0);
		setm(9'h023, 8'h55);
		wr(BAM_REG_BREG, 8'hfe);
		wr(BAM_REG_PSW, 8'hc4);
		for (int i = 0; i < 12; i++) begin
			wr(BAM_REG_ACC, lg_tab[i][31:24]);
			exec(lg_tab[i][23:16], lg_tab[i][15:8], 1, 0);
			rdchk(BAM_REG_ACC, {24'h0, lg_tab[i][7:0]});
			rdchk(BAM_REG_PSW, 32'hc4);
		end
		end_of_test();
	end
endmodule // bam_core_tb

// >>> hdl/bam_core.sv
// Purpose: execution datapath for decrement, multiply, divide and logic ops
// Assumes: one 40 MHz clock, async active-high reset, classic wishbone slave
// Notes:   a command write launches one instruction; data space is 512 bytes
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/100ps

// Overview of operation
// - opcodes 74H-77H decrement the byte an indirect pointer addresses, one cycle.
// - indirect decrement keeps carry, aux carry and overflow unchanged, even on wrap.
// - decrement of port one or three modifies the output latch, not pins.
// - decrement aimed at port seven leaves that port unchanged.
// - opcode 30H multiplies {acc,c} by b, unsigned, in seven cycles.
// - product bits 7:0 to c, 15:8 to acc, 23:16 to b.
// - multiply sets overflow when top byte nonzero, keeps aux carry.
// - multiply always clears carry at its end.
// - during multiply or divide, interrupts accepted only on the seventh cycle.
// - opcode 40H divides {acc,c} by b, unsigned, in seven cycles.
// - divide puts quotient high in acc, low in c, remainder in b.
// - divide by zero sets acc to FFH and sets overflow.
// - nonzero divisor clears overflow; carry cleared after every divide.
// - AND uses E1 immediate, E2H-E3H direct, E4H-E7H indirect, one cycle.
// - OR uses D1H immediate, D2H-D3H direct, D4H-D7H indirect, one cycle.
// - XOR direct uses F2H-F3H, two bytes, one cycle, result to acc.
// - immediate XOR combines acc with second byte into acc.
// - direct forms take address bit 8 from opcode bit 0, low byte following.
// - indirect forms pick one of four pointers by opcode bits 1:0.
module bam_core
	import bam_pkg::*;
(
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// port pins and latches
	input  wire logic [7:0]  i_port_one_pins,
	input  wire logic [7:0]  i_port_three_pins,
	output logic      [7:0]  o_port_one,
	output logic      [7:0]  o_port_three,
	output logic      [7:0]  o_port_seven,
	// execution status
	output logic             o_busy,
	output logic             o_int_window
);

	// state registers
	bam_state_e  state_q,    state_d;
	logic [2:0]  cnt_q,      cnt_d;
	logic [7:0]  op_q,       op_d;
	logic [7:0]  imm_q,      imm_d;
	logic [7:0]  acc_q,      acc_d;
	logic [7:0]  b_q,        b_d;
	logic [7:0]  c_q,        c_d;
	logic        cy_q,       cy_d;
	logic        ac_q,       ac_d;
	logic        ov_q,       ov_d;
	logic [7:0]  p1_q,       p1_d;
	logic [7:0]  p3_q,       p3_d;
	logic [7:0]  p7_q,       p7_d;
	logic [8:0]  maddr_q,    maddr_d;
	logic        ack_q,      ack_d;
	logic [31:0] dat_q,      dat_d;
	logic [7:0]  mem_q [0:511];

	// memory write port
	logic        mem_we;
	logic [8:0]  mem_wa;
	logic [7:0]  mem_wd;

	// datapath helpers
	logic [7:0]  ptr_val;
	logic [8:0]  ea;
	logic [7:0]  opnd;
	logic [7:0]  lval;
	logic [23:0] prod;
	logic [15:0] quot;
	logic [15:0] rem16;
	logic        is_dec;
	logic        is_mul;
	logic        is_div;
	logic        is_logic;
	logic        last_long;
	logic        bus_req;
	logic        bus_wr;
	logic [7:0]  psw_byte;

	// decode and effective address
	always_comb begin
		is_dec   = (op_q[7:2] == BAM_OP_DEC_HI);
		is_mul   = (op_q == BAM_OP_MUL);
		is_div   = (op_q == BAM_OP_DIV);
		is_logic = ((op_q[7:4] == BAM_GRP_AND) || (op_q[7:4] == BAM_GRP_OR) ||
			(op_q[7:4] == BAM_GRP_XOR)) && (op_q[3] == 1'b0) && (op_q[2:0] != 3'h0);
		ptr_val  = mem_q[{7'h00, op_q[1:0]}];
		if (op_q[2]) begin
			ea = {op_q[1], ptr_val};
		end else begin
			ea = {op_q[0], imm_q};
		end
		last_long = (state_q == BAM_ST_LONG) && (cnt_q == BAM_LONG_CYCLES);
		psw_byte  = BAM_RST_BYTE;
		psw_byte[BAM_PSW_CY] = cy_q;
		psw_byte[BAM_PSW_AC] = ac_q;
		psw_byte[BAM_PSW_OV] = ov_q;
	end

	// operand fetch from the data space
	always_comb begin
		case (ea)
			BAM_SFR_ACC:   opnd = acc_q;
			BAM_SFR_BREG:  opnd = b_q;
			BAM_SFR_CREG:  opnd = c_q;
			BAM_SFR_PORT1: opnd = p1_q;
			BAM_SFR_PORT3: opnd = p3_q;
			BAM_SFR_PORT7: opnd = p7_q;
			default:       opnd = mem_q[ea];
		endcase
		if (op_q[3:0] == BAM_LO_IMM) begin
			lval = imm_q;
		end else begin
			lval = opnd;
		end
	end

	// multiply and divide arithmetic
	always_comb begin
		prod = {8'h00, acc_q, c_q} * {16'h0000, b_q};
		if (b_q == BAM_RST_BYTE) begin
			quot  = 16'hffff;
			rem16 = 16'h0000;
		end else begin
			quot  = {acc_q, c_q} / {8'h00, b_q};
			rem16 = {acc_q, c_q} % {8'h00, b_q};
		end
	end

	// wishbone request qualification
	always_comb begin
		bus_req = i_wb_cyc && i_wb_stb && !ack_q;
		bus_wr  = bus_req && i_wb_we && i_wb_sel[0] && (state_q == BAM_ST_IDLE);
	end

	// next state of sequencer, registers and bus answer
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		op_d    = op_q;
		imm_d   = imm_q;
		acc_d   = acc_q;
		b_d     = b_q;
		c_d     = c_q;
		cy_d    = cy_q;
		ac_d    = ac_q;
		ov_d    = ov_q;
		p1_d    = p1_q;
		p3_d    = p3_q;
		p7_d    = p7_q;
		maddr_d = maddr_q;
		mem_we  = 1'b0;
		mem_wa  = ea;
		mem_wd  = opnd - 8'h01;
		ack_d   = bus_req;
		dat_d   = dat_q;
		// register reads
		if (bus_req && !i_wb_we) begin
			case (i_wb_adr)
				BAM_REG_CMD:      dat_d = {16'h0000, imm_q, op_q};
				BAM_REG_STATUS:   dat_d = {30'h0, o_int_window, o_busy};
				BAM_REG_ACC:      dat_d = {24'h0, acc_q};
				BAM_REG_BREG:     dat_d = {24'h0, b_q};
				BAM_REG_CREG:     dat_d = {24'h0, c_q};
				BAM_REG_PSW:      dat_d = {24'h0, psw_byte};
				BAM_REG_MEM_ADDR: dat_d = {23'h0, maddr_q};
				BAM_REG_MEM_DATA: dat_d = {24'h0, mem_q[maddr_q]};
				BAM_REG_PORT1:    dat_d = {24'h0, p1_q};
				BAM_REG_PORT3:    dat_d = {24'h0, p3_q};
				BAM_REG_PORT7:    dat_d = {24'h0, p7_q};
				BAM_REG_PINS:     dat_d = {16'h0, i_port_three_pins, i_port_one_pins};
				default:          dat_d = 32'h0000_0000;
			endcase
		end
		// register writes, only while idle
		if (bus_wr) begin
			case (i_wb_adr)
				BAM_REG_CMD: begin
					op_d  = i_wb_dat[7:0];
					imm_d = i_wb_sel[1] ? i_wb_dat[15:8] : BAM_RST_BYTE;
					cnt_d = 3'h1;
					if ((i_wb_dat[7:0] == BAM_OP_MUL) || (i_wb_dat[7:0] == BAM_OP_DIV)) begin
						state_d = BAM_ST_LONG;
					end else begin
						state_d = BAM_ST_EXEC;
					end
				end
				BAM_REG_ACC:      acc_d = i_wb_dat[7:0];
				BAM_REG_BREG:     b_d   = i_wb_dat[7:0];
				BAM_REG_CREG:     c_d   = i_wb_dat[7:0];
				BAM_REG_PSW: begin
					cy_d = i_wb_dat[BAM_PSW_CY];
					ac_d = i_wb_dat[BAM_PSW_AC];
					ov_d = i_wb_dat[BAM_PSW_OV];
				end
				BAM_REG_MEM_ADDR: maddr_d = i_wb_dat[8:0];
				BAM_REG_MEM_DATA: begin
					mem_we = 1'b1;
					mem_wa = maddr_q;
					mem_wd = i_wb_dat[7:0];
				end
				BAM_REG_PORT1:    p1_d = i_wb_dat[7:0];
				BAM_REG_PORT3:    p3_d = i_wb_dat[7:0];
				BAM_REG_PORT7:    p7_d = i_wb_dat[7:0];
				default: begin
				end
			endcase
		end
		// instruction execution
		case (state_q)
			BAM_ST_IDLE: begin
			end
			BAM_ST_EXEC: begin
				state_d = BAM_ST_IDLE;
				if (is_dec) begin
					// flags left alone on purpose
					case (ea)
						BAM_SFR_ACC:   acc_d = opnd - 8'h01;
						BAM_SFR_BREG:  b_d   = opnd - 8'h01;
						BAM_SFR_CREG:  c_d   = opnd - 8'h01;
						BAM_SFR_PORT1: p1_d  = p1_q - 8'h01;
						BAM_SFR_PORT3: p3_d  = p3_q - 8'h01;
						BAM_SFR_PORT7: p7_d  = p7_q;
						default:       mem_we = 1'b1;
					endcase
				end else if (is_logic) begin
					// flags untouched by logic ops
					case (op_q[7:4])
						BAM_GRP_AND: acc_d = acc_q & lval;
						BAM_GRP_OR:  acc_d = acc_q | lval;
						default:     acc_d = acc_q ^ lval;
					endcase
				end
			end
			BAM_ST_LONG: begin
				cnt_d = cnt_q + 3'h1;
				if (last_long) begin
					state_d = BAM_ST_IDLE;
					cy_d    = 1'b0;
					if (is_mul) begin
						c_d   = prod[7:0];
						acc_d = prod[15:8];
						b_d   = prod[23:16];
						ov_d  = (prod[23:16] != BAM_RST_BYTE);
					end else if (b_q == BAM_RST_BYTE) begin
						acc_d = BAM_DIV0_ACC;
						ov_d  = 1'b1;
					end else begin
						acc_d = quot[15:8];
						c_d   = quot[7:0];
						b_d   = rem16[7:0];
						ov_d  = 1'b0;
					end
				end
			end
			default: state_d = BAM_ST_IDLE;
		endcase
	end

	// control and datapath registers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= BAM_ST_IDLE;
			cnt_q   <= 3'h0;
			op_q    <= BAM_RST_BYTE;
			imm_q   <= BAM_RST_BYTE;
			acc_q   <= BAM_RST_BYTE;
			b_q     <= BAM_RST_BYTE;
			c_q     <= BAM_RST_BYTE;
			cy_q    <= 1'b0;
			ac_q    <= 1'b0;
			ov_q    <= 1'b0;
			p1_q    <= BAM_RST_BYTE;
			p3_q    <= BAM_RST_BYTE;
			p7_q    <= BAM_RST_BYTE;
			maddr_q <= 9'h000;
			ack_q   <= 1'b0;
			dat_q   <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			op_q    <= op_d;
			imm_q   <= imm_d;
			acc_q   <= acc_d;
			b_q     <= b_d;
			c_q     <= c_d;
			cy_q    <= cy_d;
			ac_q    <= ac_d;
			ov_q    <= ov_d;
			p1_q    <= p1_d;
			p3_q    <= p3_d;
			p7_q    <= p7_d;
			maddr_q <= maddr_d;
			ack_q   <= ack_d;
			dat_q   <= dat_d;
		end
	end

	// data space storage, no reset
	always_ff @(posedge i_core_clk) begin
		if (mem_we) begin
			mem_q[mem_wa] <= mem_wd;
		end
	end

	// outputs
	assign o_wb_ack     = ack_q;
	assign o_wb_dat     = dat_q;
	assign o_port_one   = p1_q;
	assign o_port_three = p3_q;
	assign o_port_seven = p7_q;
	assign o_busy       = (state_q != BAM_ST_IDLE);
	assign o_int_window = (state_q != BAM_ST_LONG) || last_long;

	// checks on execution behaviour
	AST_ONE_CYCLE: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_q == BAM_ST_EXEC |=> state_q == BAM_ST_IDLE)
		else $error("one-cycle instruction did not finish");
	AST_DEC_FLAGS: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_q == BAM_ST_EXEC) && is_dec |=> $stable({cy_q, ac_q, ov_q}))
		else $error("decrement changed flags");
	AST_DEC_PORT1: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_q == BAM_ST_EXEC) && is_dec && (ea == BAM_SFR_PORT1)
		|=> p1_q == $past(p1_q) - 8'h01)
		else $error("port one latch not decremented");
	AST_DEC_PORT7: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_q == BAM_ST_EXEC) && is_dec && (ea == BAM_SFR_PORT7)
		|=> $stable(p7_q))
		else $error("port seven changed by decrement");
	AST_LONG_LEN: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(state_q == BAM_ST_LONG)
		|-> (state_q == BAM_ST_LONG)[*7] ##1 (state_q == BAM_ST_IDLE))
		else $error("multiply or divide not seven cycles");
	AST_MUL_RESULT: assert property (@(posedge i_core_clk) disable iff (i_rst)
		last_long && is_mul |=> {b_q, acc_q, c_q} == $past(prod)
		&& ov_q == ($past(prod[23:16]) != 8'h00) && !cy_q && $stable(ac_q))
		else $error("multiply result or flags wrong");
	AST_INT_WINDOW: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_q == BAM_ST_LONG) && (cnt_q < 3'h7) |-> !o_int_window)
		else $error("interrupt window open before seventh cycle");
	AST_DIV_ZERO: assert property (@(posedge i_core_clk) disable iff (i_rst)
		last_long && is_div && (b_q == 8'h00)
		|=> acc_q == 8'hff && ov_q && !cy_q)
		else $error("divide by zero handling wrong");
	AST_DIV_OK: assert property (@(posedge i_core_clk) disable iff (i_rst)
		last_long && is_div && (b_q != 8'h00)
		|=> {acc_q, c_q} == $past(quot) && b_q == $past(rem16[7:0])
		&& !ov_q && !cy_q)
		else $error("divide result or flags wrong");
	AST_LOGIC_FLAGS: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_q == BAM_ST_EXEC) && is_logic
		|=> $stable({cy_q, ac_q, ov_q}) && $stable(b_q))
		else $error("logic op disturbed flags");

endmodule // bam_core

// >>> hdl/bam_pkg.sv
// Purpose: constants for the byte alu, multiply/divide and logic-op datapath
// Assumes: 40 MHz core clock, classic wishbone register port, 32-bit data
// Notes:   byte addresses of the register window and the data space map
package bam_pkg;
	// wishbone register window, byte addresses
	localparam logic [7:0] BAM_REG_CMD      = 8'h00;
	localparam logic [7:0] BAM_REG_STATUS   = 8'h04;
	localparam logic [7:0] BAM_REG_ACC      = 8'h08;
	localparam logic [7:0] BAM_REG_BREG     = 8'h0c;
	localparam logic [7:0] BAM_REG_CREG     = 8'h10;
	localparam logic [7:0] BAM_REG_PSW      = 8'h14;
	localparam logic [7:0] BAM_REG_MEM_ADDR = 8'h18;
	localparam logic [7:0] BAM_REG_MEM_DATA = 8'h1c;
	localparam logic [7:0] BAM_REG_PORT1    = 8'h20;
	localparam logic [7:0] BAM_REG_PORT3    = 8'h24;
	localparam logic [7:0] BAM_REG_PORT7    = 8'h28;
	localparam logic [7:0] BAM_REG_PINS     = 8'h2c;

	// program_status_word field positions
	localparam int BAM_PSW_CY = 7;
	localparam int BAM_PSW_AC = 6;
	localparam int BAM_PSW_OV = 2;

	// status field positions
	localparam int BAM_ST_BUSY  = 0;
	localparam int BAM_ST_INTWN = 1;

	// special registers seen in the 9-bit data space
	localparam logic [8:0] BAM_SFR_ACC   = 9'h100;
	localparam logic [8:0] BAM_SFR_BREG  = 9'h102;
	localparam logic [8:0] BAM_SFR_CREG  = 9'h103;
	localparam logic [8:0] BAM_SFR_PORT1 = 9'h144;
	localparam logic [8:0] BAM_SFR_PORT3 = 9'h14c;
	localparam logic [8:0] BAM_SFR_PORT7 = 9'h15c;

	// opcodes and opcode groups
	localparam logic [7:0] BAM_OP_MUL    = 8'h30;
	localparam logic [7:0] BAM_OP_DIV    = 8'h40;
	localparam logic [5:0] BAM_OP_DEC_HI = 6'h1d;
	localparam logic [3:0] BAM_GRP_AND   = 4'he;
	localparam logic [3:0] BAM_GRP_OR    = 4'hd;
	localparam logic [3:0] BAM_GRP_XOR   = 4'hf;
	localparam logic [3:0] BAM_LO_IMM    = 4'h1;

	// reset value and divide-by-zero accumulator value
	localparam logic [7:0] BAM_RST_BYTE = 8'h00;
	localparam logic [7:0] BAM_DIV0_ACC = 8'hff;

	// long instruction length in cycles
	localparam logic [2:0] BAM_LONG_CYCLES = 3'h7;

	// execution states, gray along idle -> exec -> long
	typedef enum logic [1:0] {
		BAM_ST_IDLE = 2'b00,
		BAM_ST_EXEC = 2'b01,
		BAM_ST_LONG = 2'b11
	} bam_state_e;
endpackage
